// ---- hw/sst_pkg.sv ----
// Shared constants for the servo-aware sector timing block.
// Assumes one 50 MHz core clock and a plain register port.
package sst_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] SST_CTRL     = 8'h00;
  localparam logic [7:0] SST_SRV_INT  = 8'h04;
  localparam logic [7:0] SST_SRV_LEN  = 8'h08;
  localparam logic [7:0] SST_SRV_CNT  = 8'h0C;
  localparam logic [7:0] SST_REQ_SIZE = 8'h10;
  localparam logic [7:0] SST_SEC_SIZE = 8'h14;
  localparam logic [7:0] SST_SEC_TRK  = 8'h18;
  localparam logic [7:0] SST_TRK_LEN  = 8'h1C;
  localparam logic [7:0] SST_GAP      = 8'h20;
  localparam logic [7:0] SST_CONFIG   = 8'h24;
  localparam logic [7:0] SST_STATUS   = 8'h28;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_LHS_BIT  = 3;
  localparam int CFG_LHS_BIT   = 0;
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_FAULT_BIT  = 1;
  localparam int ST_CC_BIT     = 2;
  localparam int ST_SERVO_BIT  = 3;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [3:0]  SST_CTRL_RST     = 4'h5;
  localparam logic [15:0] SST_SRV_INT_RST  = 16'h1388;
  localparam logic [7:0]  SST_SRV_LEN_RST  = 8'h20;
  localparam logic [3:0]  SST_SRV_CNT_RST  = 4'h4;
  localparam logic [15:0] SST_SEC_SIZE_RST = 16'h0465;
  localparam logic [19:0] SST_SEC_TRK_RST  = 20'h00010;
  localparam logic [15:0] SST_GAP_RST      = 16'h0010;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int SST_CLK_MHZ        = 50;
  localparam int SST_HS_SETTLE_US   = 200;
  localparam int SST_HS_SETTLE_CYC  = SST_HS_SETTLE_US * SST_CLK_MHZ;
  localparam int SST_HALF_BIT_CYC   = 2;
  localparam int SST_HALF_PER_BYTE  = 16;

  // Servo placement on the track
  typedef enum logic [1:0] {
    SST_SRV_NONE   = 2'h0,
    SST_SRV_EVERY  = 2'h1,
    SST_SRV_SPARSE = 2'h2,
    SST_SRV_CONT   = 2'h3
  } sst_srv_e;

endpackage

// ---- hw/sst_tick_if.sv ----
// Enable-in / tick-out pair between a divider and its user.
// Assumes both ends sit on core_clk.
interface sst_tick_if;
  logic en;
  logic tick;
  modport src (output en, input tick);
  modport div (input en, output tick);
endinterface

// ---- hw/sst_div.sv ----
// Clock-enable divider: one tick per N enabled cycles.
// Assumes en is a same-domain pulse or level.
module sst_div #(
  parameter int N = 2
) (
  input  wire logic clk,
  input  wire logic rst,
  sst_tick_if.div   t
);

  localparam int W = (N > 1) ? $clog2(N) : 1;
  localparam logic [W-1:0] LAST = W'(N - 1);

  logic [W-1:0] cnt_q;

  // ------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------
  // Tick is combinational so the user sees it in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (t.en) begin
      cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
    end
  end

  assign t.tick = t.en && (cnt_q == LAST);

endmodule

// ---- hw/sst_core.sv ----
// Servo-aware sector timing: servo map, index/sector pulses,
// write guard, read clock stretch, head settle and track fit.
// Assumes head and write-gate pins are asynchronous to core_clk.
//
// The placing of the registers and strobed register access were decided locally.

// Functional notes
// [RULE1] A config bit reports long head switch due to embedded servo.
// [RULE2] With long switch, command complete stays low until new head settles.
// [RULE3] Controller waits for command complete before using the new track.
// [RULE4] No recording inside servo; gap, sector size and count enforce it.
// [RULE5] Every-sector servo: gaps report servo region; writes there refused.
// [RULE6] Controller formats so no field lands in the servo gap.
// [RULE7] Sparse servo: every servo area lies inside a sector gap.
// [RULE8] Pulses each sector length; a pulse hitting servo waits past it.
// [RULE9] Servo gap stays hidden; report small gap, track length without servo.
// [RULE10] Continuous servo: stretch read clock while servo passes.
// [RULE11] Size change: whole sectors fit between servo regions.
// [RULE12] Sector size enlarged to spread sectors evenly per interval.
// [RULE13] Controller reads back adopted size and count, never divides.
// [RULE14] Byte counter from divided clock, reloads per pulse, frozen in servo.
module sst_core
  import sst_pkg::*;
#(
  parameter int HS_SETTLE_CYC = SST_HS_SETTLE_CYC,
  parameter int HALF_BIT_CYC  = SST_HALF_BIT_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [3:0]  head_sel,
  input  wire logic        write_gate,
  output logic             index_pulse,
  output logic             sector_pulse,
  output logic             read_clk,
  output logic             write_enable,
  output logic             cmd_complete
);

  localparam int SW = $clog2(HS_SETTLE_CYC + 1);
  localparam logic [SW-1:0] SETTLE_LOAD = SW'(HS_SETTLE_CYC);
  localparam logic [SW-1:0] SETTLE_ONE  = SW'(1);

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [3:0]  ctrl_q;
  logic [15:0] srv_int_q;
  logic [7:0]  srv_len_q;
  logic [3:0]  srv_cnt_q;
  logic [15:0] gap_q;
  logic [15:0] sec_size_q;
  logic [19:0] sec_trk_q;
  logic        fault_q;
  logic [31:0] rdata_q;
  logic [16:0] per_pos_q;
  logic [3:0]  reg_idx_q;
  logic [15:0] seg_cnt_q;
  logic        index_q;
  logic        sector_q;
  logic        rclk_q;
  logic        we_q;
  logic        cc_q;
  logic [SW-1:0] settle_q;
  logic [3:0]  hs_m_q;
  logic [3:0]  hs_s_q;
  logic [3:0]  hs_prev_q;
  logic        wg_m_q;
  logic        wg_s_q;
  logic        enable;
  logic        lhs;
  sst_srv_e    mode;
  logic [19:0] trk_len;
  logic [16:0] per_len;
  logic        in_servo;
  logic        nxt_servo;
  logic        srv_next;
  logic        per_last;
  logic        trk_last;
  logic        seg_full;
  logic        hs_chg;
  logic [15:0] rep_gap;
  logic        half_tick;
  logic        byte_tick;
  logic        req_wr;

  sst_tick_if half_if ();
  sst_tick_if byte_if ();

  // ------------------------------------------------------------
  // Byte clock from the reference rate
  // ------------------------------------------------------------
  // Half-bit enable, then sixteen half bits per byte
  assign half_if.en = 1'b1;
  assign byte_if.en = half_if.tick;
  assign half_tick  = half_if.tick;
  assign byte_tick  = byte_if.tick; // [RULE14]

  sst_div #(.N(HALF_BIT_CYC)) u_half_div (
    .clk (core_clk),
    .rst (rst),
    .t   (half_if)
  );

  sst_div #(.N(SST_HALF_PER_BYTE)) u_byte_div (
    .clk (core_clk),
    .rst (rst),
    .t   (byte_if)
  );

  // ------------------------------------------------------------
  // Control decode
  // ------------------------------------------------------------
  assign enable  = ctrl_q[CTRL_EN_BIT];
  assign lhs     = ctrl_q[CTRL_LHS_BIT];
  assign mode    = sst_srv_e'(ctrl_q[CTRL_MODE_LSB +: 2]);
  assign trk_len = 20'(srv_int_q) * 20'(srv_cnt_q); // [RULE9]
  assign req_wr  = reg_wr && (reg_addr == SST_REQ_SIZE);

  // Every-sector servo shows the servo span as the gap
  assign rep_gap = (mode == SST_SRV_EVERY) ? {8'h00, srv_len_q} : gap_q; // [RULE5] [RULE9]

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  // Two flops; only the second stage feeds logic
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hs_m_q <= 4'h0;
      hs_s_q <= 4'h0;
      wg_m_q <= 1'b0;
      wg_s_q <= 1'b0;
    end else begin
      hs_m_q <= head_sel;
      hs_s_q <= hs_m_q;
      wg_m_q <= write_gate;
      wg_s_q <= wg_m_q;
    end
  end

  // ------------------------------------------------------------
  // Servo map along the physical track
  // ------------------------------------------------------------
  // Each period is data first, then its servo region
  assign per_len   = (mode == SST_SRV_NONE) ? {1'b0, srv_int_q}
                   : {1'b0, srv_int_q} + {9'h000, srv_len_q};
  assign in_servo  = per_pos_q >= {1'b0, srv_int_q};
  assign per_last  = per_pos_q >= per_len - 17'h00001;
  assign trk_last  = per_last && (reg_idx_q >= srv_cnt_q - 4'h1);
  assign nxt_servo = !per_last && (per_pos_q + 17'h00001 >= {1'b0, srv_int_q});
  assign srv_next  = byte_tick ? nxt_servo : in_servo;

  // Position keeps moving even while the controller view is frozen
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      per_pos_q <= 17'h00000;
      reg_idx_q <= 4'h0;
    end else if (!enable) begin
      per_pos_q <= 17'h00000;
      reg_idx_q <= 4'h0;
    end else if (byte_tick) begin
      if (per_last) begin
        per_pos_q <= 17'h00000;
        reg_idx_q <= trk_last ? 4'h0 : reg_idx_q + 4'h1;
      end else begin
        per_pos_q <= per_pos_q + 17'h00001;
      end
    end
  end

  // ------------------------------------------------------------
  // Index and sector pulses
  // ------------------------------------------------------------
  assign seg_full = seg_cnt_q >= sec_size_q - 16'h0001;

  // A full count waits through servo so the pulse lands after it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      seg_cnt_q <= 16'h0000;
      index_q   <= 1'b0;
      sector_q  <= 1'b0;
    end else begin
      index_q  <= 1'b0;
      sector_q <= 1'b0;
      if (!enable) begin
        seg_cnt_q <= 16'h0000;
      end else if (byte_tick && trk_last) begin
        seg_cnt_q <= 16'h0000; // [RULE8]
        index_q   <= 1'b1;
      end else if (byte_tick) begin
        if (seg_full && !nxt_servo) begin
          seg_cnt_q <= 16'h0000; // [RULE14]
          sector_q  <= 1'b1;     // [RULE7] [RULE8]
        end else if (!in_servo && !seg_full) begin
          seg_cnt_q <= seg_cnt_q + 16'h0001; // [RULE14]
        end
      end
    end
  end

  assign index_pulse  = index_q;
  assign sector_pulse = sector_q;

  sequence servo_byte_s;
    in_servo && byte_tick && !seg_full && !trk_last && enable; // Track-end reload is legal
  endsequence

  chk_count_frozen_servo: assert property ( // [RULE14]
    servo_byte_s |=> $stable(seg_cnt_q))
    else $error("sector count moved inside servo");

  chk_no_pulse_servo: assert property ( // [RULE7]
    (sector_q || index_q) |-> !in_servo)
    else $error("pulse issued inside servo region");

  chk_pulse_postponed: assert property ( // [RULE8]
    (byte_tick && seg_full && nxt_servo && !trk_last && enable) |=> !sector_q)
    else $error("sector pulse not postponed past servo");

  // ------------------------------------------------------------
  // Read clock with servo stretch
  // ------------------------------------------------------------
  // Holding the level hides servo bytes from the controller
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rclk_q <= 1'b0;
    end else if (half_tick && !(mode == SST_SRV_CONT && in_servo)) begin
      rclk_q <= ~rclk_q; // [RULE10]
    end
  end

  assign read_clk = rclk_q;

  chk_rdclk_stretch: assert property ( // [RULE10]
    (mode == SST_SRV_CONT && in_servo) |=> $stable(rclk_q))
    else $error("read clock toggled over servo");

  // ------------------------------------------------------------
  // Write guard
  // ------------------------------------------------------------
  // Uses next-cycle servo state so the enable never overlaps servo
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      we_q <= 1'b0;
    end else begin
      we_q <= wg_s_q && enable && !srv_next; // [RULE4] [RULE5]
    end
  end

  assign write_enable = we_q;

  sequence servo_write_s;
    wg_s_q && in_servo && enable;
  endsequence

  chk_no_write_servo: assert property ( // [RULE4]
    in_servo |-> !we_q)
    else $error("write enabled inside servo region");

  chk_fault_flagged: assert property ( // [RULE5]
    servo_write_s |=> fault_q)
    else $error("refused write not flagged");

  // ------------------------------------------------------------
  // Head switch settle
  // ------------------------------------------------------------
  assign hs_chg = hs_s_q != hs_prev_q;

  // Short-switch drives leave command complete asserted
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hs_prev_q <= 4'h0;
      settle_q  <= '0;
      cc_q      <= 1'b1;
    end else begin
      hs_prev_q <= hs_s_q;
      if (hs_chg && lhs) begin
        cc_q     <= 1'b0; // [RULE2]
        settle_q <= SETTLE_LOAD;
      end else if (settle_q != '0) begin
        settle_q <= settle_q - SETTLE_ONE;
        if (settle_q == SETTLE_ONE) begin
          cc_q <= 1'b1; // [RULE2]
        end
      end
    end
  end

  assign cmd_complete = cc_q;

  sequence head_change_s;
    hs_chg && lhs;
  endsequence

  chk_cc_drops_switch: assert property ( // [RULE2]
    head_change_s |=> !cc_q)
    else $error("command complete high after head change");

  chk_cc_after_settle: assert property ( // [RULE2]
    $rose(cc_q) |-> $past(settle_q) == SETTLE_ONE)
    else $error("command complete rose before settle done");

  // ------------------------------------------------------------
  // Track fit for a new unformatted sector size
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    FS_IDLE   = 3'b001,
    FS_FIT    = 3'b010,
    FS_SPREAD = 3'b100
  } sst_fit_e;

  sst_fit_e    fs_q;
  logic [19:0] rem_q;
  logic [15:0] div_q;
  logic [15:0] quo_q;
  logic [15:0] req_q;
  logic [15:0] spi_q;

  // Repeated subtraction: slow but tiny, and only runs on request
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fs_q       <= FS_IDLE;
      rem_q      <= 20'h00000;
      div_q      <= 16'h0001;
      quo_q      <= 16'h0000;
      req_q      <= 16'h0000;
      spi_q      <= 16'h0001;
      sec_size_q <= SST_SEC_SIZE_RST;
      sec_trk_q  <= SST_SEC_TRK_RST;
    end else begin
      unique case (fs_q)
        FS_IDLE: begin
          if (req_wr) begin
            rem_q <= (mode == SST_SRV_NONE) ? trk_len : {4'h0, srv_int_q};
            div_q <= (reg_wdata[15:0] == 16'h0000) ? 16'h0001 : reg_wdata[15:0];
            req_q <= reg_wdata[15:0];
            quo_q <= 16'h0000;
            fs_q  <= FS_FIT;
          end
        end
        FS_FIT: begin
          if (rem_q >= {4'h0, div_q}) begin
            rem_q <= rem_q - {4'h0, div_q};
            quo_q <= quo_q + 16'h0001;
          end else if (mode == SST_SRV_NONE) begin
            sec_size_q <= req_q;
            sec_trk_q  <= {4'h0, quo_q};
            fs_q       <= FS_IDLE;
          end else begin
            spi_q <= (quo_q == 16'h0000) ? 16'h0001 : quo_q; // [RULE11]
            div_q <= (quo_q == 16'h0000) ? 16'h0001 : quo_q;
            rem_q <= {4'h0, srv_int_q};
            quo_q <= 16'h0000;
            fs_q  <= FS_SPREAD;
          end
        end
        FS_SPREAD: begin
          if (rem_q >= {4'h0, div_q}) begin
            rem_q <= rem_q - {4'h0, div_q};
            quo_q <= quo_q + 16'h0001;
          end else begin
            sec_size_q <= quo_q;                      // [RULE12]
            sec_trk_q  <= 20'(spi_q) * 20'(srv_cnt_q); // [RULE11]
            fs_q       <= FS_IDLE;
          end
        end
        default: fs_q <= FS_IDLE;
      endcase
    end
  end

  chk_fit_whole: assert property ( // [RULE11]
    (fs_q == FS_SPREAD && rem_q < {4'h0, div_q})
      |=> (sec_trk_q == 20'(spi_q) * 20'(srv_cnt_q)) && (32'(sec_size_q) * 32'(spi_q) <= 32'(srv_int_q)))
    else $error("sectors do not fit whole per servo interval");

  chk_fit_spread: assert property ( // [RULE12]
    (fs_q == FS_SPREAD && rem_q < {4'h0, div_q})
      |=> 32'(srv_int_q) - 32'(sec_size_q) * 32'(spi_q) < 32'(spi_q))
    else $error("sector size not spread over interval");

  // ------------------------------------------------------------
  // Register writes and status
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_q    <= SST_CTRL_RST;
      srv_int_q <= SST_SRV_INT_RST;
      srv_len_q <= SST_SRV_LEN_RST;
      srv_cnt_q <= SST_SRV_CNT_RST;
      gap_q     <= SST_GAP_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        SST_CTRL:    ctrl_q    <= reg_wdata[3:0];
        SST_SRV_INT: srv_int_q <= reg_wdata[15:0];
        SST_SRV_LEN: srv_len_q <= reg_wdata[7:0];
        SST_SRV_CNT: srv_cnt_q <= reg_wdata[3:0];
        SST_GAP:     gap_q     <= reg_wdata[15:0];
        default: ;
      endcase
    end
  end

  // Set beats clear so a refusal in the clear cycle survives
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fault_q <= 1'b0;
    end else if (wg_s_q && in_servo && enable) begin
      fault_q <= 1'b1; // [RULE5]
    end else if (reg_wr && reg_addr == SST_STATUS && reg_wdata[ST_FAULT_BIT]) begin
      fault_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Register reads
  // ------------------------------------------------------------
  // Unmapped offsets read zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= 32'h0000_0000;
      if (reg_rd) begin
        unique case (reg_addr)
          SST_CTRL:     rdata_q <= {28'h0000000, ctrl_q};
          SST_SRV_INT:  rdata_q <= {16'h0000, srv_int_q};
          SST_SRV_LEN:  rdata_q <= {24'h000000, srv_len_q};
          SST_SRV_CNT:  rdata_q <= {28'h0000000, srv_cnt_q};
          SST_REQ_SIZE: rdata_q <= {16'h0000, req_q};
          SST_SEC_SIZE: rdata_q <= {16'h0000, sec_size_q};
          SST_SEC_TRK:  rdata_q <= {12'h000, sec_trk_q};
          SST_TRK_LEN:  rdata_q <= {12'h000, trk_len};   // [RULE9]
          SST_GAP:      rdata_q <= {rep_gap, rep_gap};   // [RULE5] [RULE9]
          SST_CONFIG:   rdata_q <= {31'h00000000, lhs};  // [RULE1]
          SST_STATUS: begin
            rdata_q[ST_BUSY_BIT]  <= fs_q != FS_IDLE;
            rdata_q[ST_FAULT_BIT] <= fault_q;
            rdata_q[ST_CC_BIT]    <= cc_q;
            rdata_q[ST_SERVO_BIT] <= in_servo;
          end
          default: ;
        endcase
      end
    end
  end

  assign reg_rdata = rdata_q;

  chk_cfg_bit_shown: assert property ( // [RULE1]
    (reg_rd && reg_addr == SST_CONFIG) |=> reg_rdata[CFG_LHS_BIT] == $past(lhs))
    else $error("config bit does not show long head switch");

  chk_gap_hidden: assert property ( // [RULE9]
    (reg_rd && reg_addr == SST_GAP && mode == SST_SRV_SPARSE)
      |=> reg_rdata[15:0] == $past(gap_q))
    else $error("reported gap includes hidden servo span");

endmodule

// ---- test/sst_ctl_model.sv ----
// Disk controller stand-in: drives head select and write gate.
// Assumes the drive answers on core_clk; the pins are driven off its edges.
module sst_ctl_model (
  input  wire logic       core_clk,
  input  wire logic       cmd_complete,
  output logic      [3:0] head_sel,
  output logic            write_gate
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle pins at time zero
  initial begin
    head_sel   = 4'h0;
    write_gate = 1'b0;
  end

  // New head, then hold off media use until complete returns
  task automatic switch_head(input logic [3:0] h, output int low_cyc);
    low_cyc = 0;
    @(posedge core_clk) head_sel <= h;
    for (int n = 0; n < 200; n++) begin
      @(negedge core_clk);
      if (cmd_complete === 1'b0) begin
        low_cyc++;
      end else if (low_cyc > 0) begin
        break;
      end
    end
    @(posedge core_clk);
  endtask

  // Gate held blindly over servo; only the guard test asks for this misuse
  task automatic hold_gate(input int cyc);
    @(posedge core_clk) write_gate <= 1'b1;
    repeat (cyc) @(posedge core_clk);
    write_gate <= 1'b0;
  endtask
endmodule

// ---- test/servo_aware_sector_timing_test.sv ----
// Self-checking bench for the sector timing core.
// Assumes a short settle count and a small servo map to keep the run brief.
module servo_aware_sector_timing_test import sst_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic        core_clk;
  logic        rst;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [3:0]  head_sel;
  logic        write_gate;
  logic        index_pulse;
  logic        sector_pulse;
  logic        read_clk;
  logic        write_enable;
  logic        cmd_complete;
  int          err_total;
  int          total_checks;

  sst_core #(.HS_SETTLE_CYC(20), .HALF_BIT_CYC(2)) uut (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .head_sel(head_sel),
    .write_gate(write_gate), .index_pulse(index_pulse), .sector_pulse(sector_pulse),
    .read_clk(read_clk), .write_enable(write_enable), .cmd_complete(cmd_complete));

  sst_ctl_model ctl (.core_clk(core_clk), .cmd_complete(cmd_complete),
    .head_sel(head_sel), .write_gate(write_gate));

  // 50 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // ------------------------------------------------------------
  // Bus and check tasks
  // ------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Gap cycle after each strobe so no signal is assigned twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk) reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk) reg_rd <= 1'b0;
    @(negedge core_clk) d = reg_rdata;
    @(posedge core_clk);
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(what, d, exp);
  endtask

  // Poll busy under a bound; a hang ends the run
  task automatic wait_fit;
    logic [31:0] d;
    for (int n = 0; n < 4000; n++) begin
      rd(SST_STATUS, d);
      if (d[ST_BUSY_BIT] === 1'b0) return;
    end
    err_total++;
    wrap_up();
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  logic [31:0] fit_tab [3][3] = '{'{1024, 1250, 16}, '{2048, 2500, 8}, '{4096, 5000, 4}};
  logic [31:0] rst_tab [8][2] = '{'{SST_CTRL, 5}, '{SST_SRV_INT, 32'h1388}, '{SST_SRV_LEN, 32'h20},
    '{SST_SRV_CNT, 4}, '{SST_SEC_SIZE, 32'h465}, '{SST_SEC_TRK, 32'h10}, '{SST_CONFIG, 0}, '{8'h30, 0}};
  int low_cyc;
  int gap;
  int igap;
  int cnt;
  int ev;
  logic last;
  logic [31:0] d;

  initial begin
    err_total    = 0;
    total_checks = 0;
    reg_addr     = 8'h00;
    reg_wdata    = 32'h0;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    rst          = 1'b1;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    // Reset values, unmapped place ignores writes
    wr(8'h30, 32'hFFFF_FFFF);
    foreach (rst_tab[i]) rchk("reset value", rst_tab[i][0][7:0], rst_tab[i][1]);
    $display("test reset done");
    // Size fit over 5000-byte intervals; adopted values read back
    foreach (fit_tab[i]) begin
      wr(SST_REQ_SIZE, fit_tab[i][0]);
      wait_fit();
      rchk("sector size", SST_SEC_SIZE, fit_tab[i][1]);
      rchk("sectors", SST_SEC_TRK, fit_tab[i][2]);
    end
    rchk("track len", SST_TRK_LEN, 32'h4E20);
    $display("test fit done");
    // Head switch with and without the long-switch setting
    wr(SST_CTRL, 32'hD);
    rchk("config", SST_CONFIG, 1);
    ctl.switch_head(4'h3, low_cyc);
    check("settle low", low_cyc >= 20 && low_cyc <= 22, 1);
    wr(SST_CTRL, 32'h5);
    rchk("config", SST_CONFIG, 0);
    ctl.switch_head(4'h5, low_cyc);
    check("short switch", low_cyc, 0);
    $display("test head done");
    // Small map: 20 data bytes, 4 servo bytes, 4 regions, 10-byte sectors
    wr(SST_SRV_INT, 20);
    wr(SST_SRV_LEN, 4);
    wait_fit();
    wr(SST_REQ_SIZE, 10);
    wait_fit();
    rchk("sectors", SST_SEC_TRK, 8);
    wr(SST_CTRL, 32'h3);
    rchk("gap every", SST_GAP, 32'h0004_0004);
    wr(SST_CTRL, 32'h5);
    rd(SST_GAP, d);
    check("gap small", d[15:0], 32'h10);
    // Pulse spacing: 10 bytes of data, or 14 when servo sits between
    repeat (3072) @(posedge core_clk);
    gap = 0;
    igap = 0;
    ev = 0;
    cnt = 0;
    repeat (6200) begin
      @(negedge core_clk);
      gap++;
      igap++;
      if (index_pulse === 1'b1) begin
        if (cnt > 0) check("index gap", igap, 3072);
        cnt++;
        igap = 0;
      end
      if (sector_pulse === 1'b1 || index_pulse === 1'b1) begin
        if (ev > 0) check("pulse gap", gap == 320 || gap == 448, 1);
        ev++;
        gap = 0;
      end
    end
    check("index seen", cnt >= 2, 1);
    $display("test pulses done");
    // Gate held across two periods: media sees data bytes only
    cnt = 0;
    fork
      ctl.hold_gate(1600);
      begin
        repeat (20) @(posedge core_clk);
        repeat (1536) begin
          @(negedge core_clk);
          if (write_enable === 1'b1) cnt++;
        end
      end
    join
    check("write cycles", cnt, 1280);
    rd(SST_STATUS, d);
    check("fault", d[ST_FAULT_BIT], 1);
    wr(SST_STATUS, 32'h2);
    rd(SST_STATUS, d);
    check("fault clear", d[ST_FAULT_BIT], 0);
    $display("test guard done");
    // Continuous servo: read clock stands still over servo bytes
    wr(SST_CTRL, 32'h7);
    repeat (100) @(posedge core_clk);
    cnt = 0;
    @(negedge core_clk) last = read_clk;
    repeat (1536) begin
      @(negedge core_clk);
      if (read_clk !== last) cnt++;
      last = read_clk;
    end
    check("clock edges", cnt, 640);
    $display("test stretch done");
    // No servo: size taken as asked, count from track length
    wr(SST_CTRL, 32'h1);
    wr(SST_REQ_SIZE, 30);
    wait_fit();
    rchk("flat size", SST_SEC_SIZE, 30);
    rchk("flat sectors", SST_SEC_TRK, 2);
    // Oversized sectors under sparse servo hold the count over servo bytes
    wr(SST_CTRL, 32'h5);
    repeat (3100) @(posedge core_clk);
    $display("test flat done");
    wrap_up();
  end
endmodule
